// ---- core/port_io_latch_and_skip.sv ----
// Purpose: Port 3 and 4 latches, their mode registers, and port 2/3 skip masks
// Assumes: Core issues single-cycle read or write strobes in the register space
// Notes:   Read data arrives one clock after the read strobe; pins are synchronous
`timescale 1ns/10ps
module port_io_latch_and_skip #(
	parameter int unsigned WIDTH = port_io_pkg::PORT_W
) (
	input  wire logic                            core_clk,
	input  wire logic                            rst_b,
	input  wire port_io_pkg::sfr_req_s           sfr_req,
	output      logic [port_io_pkg::PORT_W-1:0]  sfr_rdata,
	output      logic                            sfr_rvalid,
	output      logic                            sfr_hit,
	input  wire logic [port_io_pkg::PORT_W-1:0]  port3_pin_in,
	output      port_io_pkg::pin_drive_s         port3_pin,
	input  wire logic [port_io_pkg::PORT_W-1:0]  port4_pin_in,
	output      port_io_pkg::pin_drive_s         port4_pin,
	output      logic [port_io_pkg::PORT_W-1:0]  port2_crossbar_allow,
	output      logic [port_io_pkg::PORT_W-1:0]  port3_crossbar_allow
);
	import port_io_pkg::*;

	// The register layout is fixed at eight bits per port
	if (WIDTH != PORT_W) begin : g_width_check
		$error("port_io_latch_and_skip: WIDTH must equal the register width");
	end

	logic [1:0]        rst_sync_reg;
	logic              rst_n_int;
	logic [WIDTH-1:0]  port3_output_latch_reg;
	logic [WIDTH-1:0]  port4_output_latch_reg;
	logic [WIDTH-1:0]  port2_skip_mask_reg;
	logic [WIDTH-1:0]  port3_skip_mask_reg;
	logic [WIDTH-1:0]  port3_input_select_reg;
	logic [WIDTH-1:0]  port4_input_select_reg;
	logic [WIDTH-1:0]  port3_drive_select_reg;
	logic [WIDTH-1:0]  port4_drive_select_reg;
	logic [WIDTH-1:0]  port3_pin_reg;
	logic [WIDTH-1:0]  port4_pin_reg;
	logic [WIDTH-1:0]  port3_read_value;
	logic [WIDTH-1:0]  port4_read_value;
	logic [WIDTH-1:0]  port3_pin_out;
	logic [WIDTH-1:0]  port3_pin_oe;
	logic [WIDTH-1:0]  port4_pin_out;
	logic [WIDTH-1:0]  port4_pin_oe;
	logic [WIDTH-1:0]  rdata_next;
	logic              hit_next;
	logic [WIDTH-1:0]  sfr_rdata_reg;
	logic              sfr_rvalid_reg;
	logic              sfr_hit_reg;

	// Reset release through two flops; assertion stays asynchronous
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			rst_sync_reg <= RST_SYNC_RESET;
		end else begin
			rst_sync_reg <= {rst_sync_reg[0], 1'b1};
		end
	end

	assign rst_n_int = rst_sync_reg[1];

	// Port 3 output latch
	always_ff @(posedge core_clk or negedge rst_n_int) begin
		if (!rst_n_int) begin
			port3_output_latch_reg <= LATCH_RESET;
		end else if (sfr_req.wr && sfr_req.addr == PORT3_OUTPUT_LATCH_ADDR) begin
			port3_output_latch_reg <= sfr_req.wdata;
		end
	end

	// Port 4 output latch
	always_ff @(posedge core_clk or negedge rst_n_int) begin
		if (!rst_n_int) begin
			port4_output_latch_reg <= LATCH_RESET;
		end else if (sfr_req.wr && sfr_req.addr == PORT4_OUTPUT_LATCH_ADDR) begin
			port4_output_latch_reg <= sfr_req.wdata;
		end
	end

	// Port 2 skip mask
	always_ff @(posedge core_clk or negedge rst_n_int) begin
		if (!rst_n_int) begin
			port2_skip_mask_reg <= SKIP_RESET;
		end else if (sfr_req.wr && sfr_req.addr == PORT2_SKIP_MASK_ADDR) begin
			port2_skip_mask_reg <= sfr_req.wdata;
		end
	end

	// Port 3 skip mask
	always_ff @(posedge core_clk or negedge rst_n_int) begin
		if (!rst_n_int) begin
			port3_skip_mask_reg <= SKIP_RESET;
		end else if (sfr_req.wr && sfr_req.addr == PORT3_SKIP_MASK_ADDR) begin
			port3_skip_mask_reg <= sfr_req.wdata;
		end
	end

	// Port 3 input select: one is digital, zero is analog
	always_ff @(posedge core_clk or negedge rst_n_int) begin
		if (!rst_n_int) begin
			port3_input_select_reg <= INPUT_SELECT_RESET;
		end else if (sfr_req.wr && sfr_req.addr == PORT3_INPUT_SELECT_ADDR) begin
			port3_input_select_reg <= sfr_req.wdata;
		end
	end

	// Port 4 input select
	always_ff @(posedge core_clk or negedge rst_n_int) begin
		if (!rst_n_int) begin
			port4_input_select_reg <= INPUT_SELECT_RESET;
		end else if (sfr_req.wr && sfr_req.addr == PORT4_INPUT_SELECT_ADDR) begin
			port4_input_select_reg <= sfr_req.wdata;
		end
	end

	// Port 3 drive select: one is push-pull, zero is open-drain
	always_ff @(posedge core_clk or negedge rst_n_int) begin
		if (!rst_n_int) begin
			port3_drive_select_reg <= DRIVE_SELECT_RESET;
		end else if (sfr_req.wr && sfr_req.addr == PORT3_DRIVE_SELECT_ADDR) begin
			port3_drive_select_reg <= sfr_req.wdata;
		end
	end

	// Port 4 drive select
	always_ff @(posedge core_clk or negedge rst_n_int) begin
		if (!rst_n_int) begin
			port4_drive_select_reg <= DRIVE_SELECT_RESET;
		end else if (sfr_req.wr && sfr_req.addr == PORT4_DRIVE_SELECT_ADDR) begin
			port4_drive_select_reg <= sfr_req.wdata;
		end
	end

	// Pin levels are captured once so a read sees one coherent byte
	always_ff @(posedge core_clk or negedge rst_n_int) begin
		if (!rst_n_int) begin
			port3_pin_reg <= '0;
			port4_pin_reg <= '0;
		end else begin
			port3_pin_reg <= port3_pin_in;
			port4_pin_reg <= port4_pin_in;
		end
	end

	// Port 3 driver and read-back
	port_pin_cell #(
		.WIDTH        (WIDTH)
	) u_port3_cell (
		.latch        (port3_output_latch_reg),
		.drive_select (port3_drive_select_reg),
		.input_select (port3_input_select_reg),
		.pin_sampled  (port3_pin_reg),
		.pin_out      (port3_pin_out),
		.pin_oe       (port3_pin_oe),
		.read_value   (port3_read_value)
	);

	// Port 4 driver and read-back
	port_pin_cell #(
		.WIDTH        (WIDTH)
	) u_port4_cell (
		.latch        (port4_output_latch_reg),
		.drive_select (port4_drive_select_reg),
		.input_select (port4_input_select_reg),
		.pin_sampled  (port4_pin_reg),
		.pin_out      (port4_pin_out),
		.pin_oe       (port4_pin_oe),
		.read_value   (port4_read_value)
	);

	// Pin structs filled in one process so each output has a single driver
	always_comb begin
		port3_pin.out = port3_pin_out;
		port3_pin.oe  = port3_pin_oe;
		port4_pin.out = port4_pin_out;
		port4_pin.oe  = port4_pin_oe;
	end

	// Crossbar may use a pin only while its skip bit is clear
	always_comb begin
		port2_crossbar_allow = ~port2_skip_mask_reg;
		port3_crossbar_allow = ~port3_skip_mask_reg;
	end

	// Read decode; latch addresses return pin state, not the stored byte
	always_comb begin
		rdata_next = UNMAPPED_READ;
		hit_next   = 1'b1;
		case (sfr_req.addr)
			PORT3_OUTPUT_LATCH_ADDR: begin
				rdata_next = port3_read_value;
			end
			PORT4_OUTPUT_LATCH_ADDR: begin
				rdata_next = port4_read_value;
			end
			PORT2_SKIP_MASK_ADDR: begin
				rdata_next = port2_skip_mask_reg;
			end
			PORT3_SKIP_MASK_ADDR: begin
				rdata_next = port3_skip_mask_reg;
			end
			PORT3_INPUT_SELECT_ADDR: begin
				rdata_next = port3_input_select_reg;
			end
			PORT4_INPUT_SELECT_ADDR: begin
				rdata_next = port4_input_select_reg;
			end
			PORT3_DRIVE_SELECT_ADDR: begin
				rdata_next = port3_drive_select_reg;
			end
			PORT4_DRIVE_SELECT_ADDR: begin
				rdata_next = port4_drive_select_reg;
			end
			default: begin
				rdata_next = UNMAPPED_READ;
				hit_next   = 1'b0;
			end
		endcase
	end

	// Read data registered; holds between reads so the core can sample late
	always_ff @(posedge core_clk or negedge rst_n_int) begin
		if (!rst_n_int) begin
			sfr_rdata_reg <= UNMAPPED_READ;
		end else if (sfr_req.rd) begin
			sfr_rdata_reg <= rdata_next;
		end
	end

	// Read-valid pulse and address-hit flag for the access just answered
	always_ff @(posedge core_clk or negedge rst_n_int) begin
		if (!rst_n_int) begin
			sfr_rvalid_reg <= 1'b0;
			sfr_hit_reg    <= 1'b0;
		end else begin
			sfr_rvalid_reg <= sfr_req.rd;
			sfr_hit_reg    <= (sfr_req.rd || sfr_req.wr) && hit_next;
		end
	end

	assign sfr_rdata  = sfr_rdata_reg;
	assign sfr_rvalid = sfr_rvalid_reg;
	assign sfr_hit    = sfr_hit_reg;

endmodule

// ---- core/port_io_pkg.sv ----
// Purpose: Shared constants and types for the port latch, mode and skip registers
// Assumes: Special-function register space with 8-bit address and 8-bit data
// Notes:   Offsets are byte addresses in that space; resets are the power-up states
package port_io_pkg;

	localparam int unsigned PORT_W = 8;
	localparam int unsigned ADDR_W = 8;

	// Register offsets in the special-function space
	localparam logic [ADDR_W-1:0] PORT3_OUTPUT_LATCH_ADDR = 8'hb0;
	localparam logic [ADDR_W-1:0] PORT4_OUTPUT_LATCH_ADDR = 8'hc7;
	localparam logic [ADDR_W-1:0] PORT2_SKIP_MASK_ADDR    = 8'hd6;
	localparam logic [ADDR_W-1:0] PORT3_SKIP_MASK_ADDR    = 8'hdf;
	localparam logic [ADDR_W-1:0] PORT4_INPUT_SELECT_ADDR = 8'hf5;
	localparam logic [ADDR_W-1:0] PORT4_DRIVE_SELECT_ADDR = 8'hae;
	localparam logic [ADDR_W-1:0] PORT3_INPUT_SELECT_ADDR = 8'hf4;
	localparam logic [ADDR_W-1:0] PORT3_DRIVE_SELECT_ADDR = 8'ha7;

	// Values after reset
	localparam logic [PORT_W-1:0] LATCH_RESET        = 8'hff;
	localparam logic [PORT_W-1:0] SKIP_RESET         = 8'h00;
	localparam logic [PORT_W-1:0] INPUT_SELECT_RESET = 8'hff;
	localparam logic [PORT_W-1:0] DRIVE_SELECT_RESET = 8'h00;
	localparam logic [PORT_W-1:0] UNMAPPED_READ      = 8'h00;
	localparam logic [1:0]        RST_SYNC_RESET     = 2'h0;

	// One access from the processor core
	typedef struct packed {
		logic              wr;
		logic              rd;
		logic [ADDR_W-1:0] addr;
		logic [PORT_W-1:0] wdata;
	} sfr_req_s;

	// Pin driver for one port: level to drive and enable
	typedef struct packed {
		logic [PORT_W-1:0] out;
		logic [PORT_W-1:0] oe;
	} pin_drive_s;

endpackage

// ---- core/port_pin_cell.sv ----
// Purpose: Output driver and read-back logic for one port of pins
// Assumes: Pin level already sampled into the clock domain by the caller
// Notes:   Purely combinational; the caller owns all state
`timescale 1ns/10ps
module port_pin_cell #(
	parameter int unsigned WIDTH = port_io_pkg::PORT_W
) (
	input  wire logic [WIDTH-1:0] latch,
	input  wire logic [WIDTH-1:0] drive_select,
	input  wire logic [WIDTH-1:0] input_select,
	input  wire logic [WIDTH-1:0] pin_sampled,
	output      logic [WIDTH-1:0] pin_out,
	output      logic [WIDTH-1:0] pin_oe,
	output      logic [WIDTH-1:0] read_value
);
	import port_io_pkg::*;

	// Refused at elaboration, so a wrong width never reaches simulation
	if (WIDTH != PORT_W) begin : g_width_check
		$error("port_pin_cell: WIDTH must equal the register width");
	end

	// On digital pins zero drives low; one drives high only in push-pull mode
	always_comb begin
		pin_out = latch;
		// Analog pins keep the digital driver off so the pin level is untouched
		pin_oe  = input_select & (~latch | drive_select);
	end

	// Analog pins read zero; digital pins read the pin, uninverted
	always_comb begin
		read_value = pin_sampled & input_select;
	end

endmodule

// ---- tb/pin_far_side.sv ----
// Purpose: Outside world of one port
// Assumes: Outside level only counts where the device releases the pin
// Notes:   No pull-up; the bench changes the outside level every pass
`timescale 1ns/10ps
module pin_far_side (
	input  wire port_io_pkg::pin_drive_s drive,
	input  wire logic [7:0]              ext,
	output      logic [7:0]              level
);
	import port_io_pkg::*;
	// Device wins where it drives, so a stale latch cannot hide a release
	assign level = (drive.oe & drive.out) | (~drive.oe & ext);
endmodule

// ---- tb/port_io_sva.sv ----
// Purpose: Register and pin relations watched at the top ports
// Assumes: One clock; rst_b low disables every check
// Notes:   Bound onto the top from the testbench file
`timescale 1ns/10ps
module port_io_sva (
	input wire logic                    core_clk,
	input wire logic                    rst_b,
	input wire port_io_pkg::sfr_req_s   sfr_req,
	input wire logic [7:0]              sfr_rdata,
	input wire logic                    sfr_rvalid,
	input wire logic                    sfr_hit,
	input wire port_io_pkg::pin_drive_s port4_pin,
	input wire logic [7:0]              port2_crossbar_allow,
	input wire logic [7:0]              port3_crossbar_allow
);
	import port_io_pkg::*;
	logic       mapped;
	logic [7:0] wa;
	// Written address, or 00 which is unmapped, so idle cycles never match
	assign wa = sfr_req.wr ? sfr_req.addr : 8'h00;
	assign mapped = sfr_req.addr inside {8'hb0, 8'hc7, 8'hd6, 8'hdf, 8'hf5, 8'hae, 8'hf4, 8'ha7};
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	a_read_answer:
		assert property (sfr_rvalid == $past(sfr_req.rd)) else $error("read answer off");
	a_rdata_hold:
		assert property (!sfr_req.rd |=> $stable(sfr_rdata)) else $error("read data moved");
	a_hit_decode:
		assert property (sfr_req.rd || sfr_req.wr |=> sfr_hit == $past(mapped))
			else $error("hit wrong");
	a_latch_drives:
		assert property (wa == 8'hc7 |=> port4_pin.out == $past(sfr_req.wdata))
			else $error("latch not on pins");
	a_skip2_allow:
		assert property (wa == 8'hd6 |=> port2_crossbar_allow == ~$past(sfr_req.wdata))
			else $error("port2 skip wrong");
	a_skip3_allow:
		assert property (wa == 8'hdf |=> port3_crossbar_allow == ~$past(sfr_req.wdata))
			else $error("port3 skip wrong");
	a_open_drain_high:
		assert property (wa == 8'hae && sfr_req.wdata == 8'h00 |=>
			(port4_pin.oe & port4_pin.out) == 8'h00) else $error("high driven");
	a_analog_off:
		assert property (wa == 8'hf5 && sfr_req.wdata == 8'h00 |=> port4_pin.oe == 8'h00)
			else $error("analog pin driven");
endmodule

// ---- tb/testbench.sv ----
// Purpose: Self-checking bench for port latches, mode registers and skip masks
// Assumes: Reads answer one clock after the strobe
// Notes:   Driver queues expected read data, monitor takes it off
`timescale 1ns/10ps
module testbench;
	import port_io_pkg::*;
	logic       core_clk    = 1'b0;
	logic       rst_b       = 1'b0;
	sfr_req_s   req         = '0;
	logic [7:0] ext3        = 8'h00;
	logic [7:0] ext4        = 8'h00;
	logic [7:0] rdata, allow2, allow3, pin3, pin4;
	logic       rvalid, hit;
	pin_drive_s drv3, drv4;
	logic [7:0] exp_q[$];
	int         failures    = 0;
	int         check_count = 0;
	int         cycles      = 0;
	// Skips, port 4 then port 3 input and drive selects, then latches 4 and 3
	logic [7:0] addrs[8]    = '{8'hd6, 8'hdf, 8'hf5, 8'hae, 8'hf4, 8'ha7, 8'hc7, 8'hb0};

	port_io_latch_and_skip i_dut (
		.core_clk(core_clk), .rst_b(rst_b), .sfr_req(req), .sfr_rdata(rdata),
		.sfr_rvalid(rvalid), .sfr_hit(hit), .port3_pin_in(pin3), .port3_pin(drv3),
		.port4_pin_in(pin4), .port4_pin(drv4), .port2_crossbar_allow(allow2),
		.port3_crossbar_allow(allow3)
	);
	pin_far_side i_far3 (.drive(drv3), .ext(ext3), .level(pin3));
	pin_far_side i_far4 (.drive(drv4), .ext(ext4), .level(pin4));

	// 200 MHz clock
	initial begin
		forever #2.5 core_clk = ~core_clk;
	end

	// Shared bookkeeping behind the compare tasks
	task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("ERROR %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic compare_read(input logic [7:0] got, input logic [7:0] exp);
		check(got, exp, "read data");
	endtask

	task automatic compare_pin(input logic [7:0] got, input logic [7:0] exp);
		check(got, exp, "pin drive");
	endtask

	task automatic compare_allow(input logic [7:0] got, input logic [7:0] exp);
		check(got, exp, "crossbar allow");
	endtask

	// One request per call, driven just after a rising edge and held until the next call replaces it
	task automatic op(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		#1 req <= '{w, r, a, d};
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		op(1'b0, 1'b1, a, 8'h00);
	endtask

	task automatic results();
		if (failures == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// Monitor: each answered read meets the oldest note; also the hang limit
	always @(posedge core_clk) begin
		cycles++;
		if (rvalid === 1'b1) begin
			compare_read(rdata, exp_q.size() ? exp_q.pop_front() : 8'hxx);
		end
		if (cycles == 2000) begin
			failures++;
			$display("ERROR %0t: timeout", $time);
			results();
		end
	end

	initial begin
		logic [7:0] d, m, ds, e, oe;
		pin_drive_s g;
		void'($urandom(32'hf7db_5669));
		repeat (2) @(posedge core_clk);
		#1 rst_b = 1'b1;
		repeat (2) op(1'b0, 1'b0, 8'h00, 8'h00);
		compare_pin(drv4.out, LATCH_RESET);
		compare_pin(drv4.oe, 8'h00);
		compare_allow(allow2 & allow3, 8'hff);
		for (int i = 0; i < 6; i++) begin
			rd(addrs[i], i < 2 ? SKIP_RESET : i % 2 ? DRIVE_SELECT_RESET : INPUT_SELECT_RESET);
		end
		rd(8'h55, UNMAPPED_READ);
		op(1'b1, 1'b0, 8'h55, 8'h3c);
		// Random contents read back; skip bits close crossbar pins
		for (int i = 0; i < 6; i++) begin
			d = 8'($urandom);
			op(1'b1, 1'b0, addrs[i], d);
			rd(addrs[i], d);
			if (i < 2) compare_allow(i ? allow3 : allow2, ~d);
		end
		// Mixed analog, open-drain and push-pull pins against random outside levels
		for (int p = 0; p < 2; p++) begin
			for (int i = 0; i < 8; i++) begin
				m = i == 0 ? 8'hff : i == 1 ? 8'h00 : 8'($urandom);
				ds = i == 0 ? 8'h00 : 8'($urandom);
				d = 8'($urandom);
				e = 8'($urandom);
				op(1'b1, 1'b0, addrs[2 + 2 * p], m);
				op(1'b1, 1'b0, addrs[3 + 2 * p], ds);
				op(1'b1, 1'b0, addrs[6 + p], d);
				op(1'b0, 1'b0, 8'h00, 8'h00);
				g = p ? drv3 : drv4;
				oe = m & (~d | ds);
				compare_pin(g.out, d);
				compare_pin(g.oe, oe);
				ext3 = p ? e : ext3;
				ext4 = p ? ext4 : e;
				rd(addrs[6 + p], ((oe & d) | (~oe & e)) & m);
			end
		end
		repeat (3) op(1'b0, 1'b0, 8'h00, 8'h00);
		// A read that never got its answer is a mismatch too
		if (exp_q.size() != 0) begin
			failures++;
			$display("ERROR %0t: reads left unanswered", $time);
		end
		results();
	end
endmodule

bind port_io_latch_and_skip port_io_sva i_sva (
	.core_clk(core_clk), .rst_b(rst_b), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
	.sfr_rvalid(sfr_rvalid), .sfr_hit(sfr_hit), .port4_pin(port4_pin),
	.port2_crossbar_allow(port2_crossbar_allow),
	.port3_crossbar_allow(port3_crossbar_allow)
);
